// ==== bench/mpwm_drv_model.sv ====
// Gate driver and event source model for the motor PWM unit
`timescale 1ns/10ps
module mpwm_drv_model (
  // Programmed polarity
  input wire logic       POL_UP,
  input wire logic       POL_LO,
  // Gate pins from the unit
  input wire logic [2:0] PHASE_UPPER,
  input wire logic [2:0] PHASE_LOWER,
  // Event requests: pos, overload, t1, t2, t3
  input wire logic [4:0] EVT_REQ,
  // Decoded gate states and events
  output logic     [2:0] UP_ON,
  output logic     [2:0] LO_ON,
  output logic     [4:0] EVT
);
  // Gate on when pin equals its active level
  assign UP_ON = POL_UP ? PHASE_UPPER : ~PHASE_UPPER;
  assign LO_ON = POL_LO ? PHASE_LOWER : ~PHASE_LOWER;
  // Event pulses pass straight through
  assign EVT = EVT_REQ;
endmodule : mpwm_drv_model

// ==== bench/mpwm_top_chk.sv ====
// Port checker for the motor PWM unit
`timescale 1ns/10ps
module mpwm_top_chk
  import mpwm_pkg::*;
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Register port
  input wire logic [15:0] ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  // Unit outputs
  input wire logic [2:0]  PHASE_UPPER,
  input wire logic [2:0]  PHASE_LOWER,
  input wire logic        PWM_INT,
  input wire logic        DEBUG_PORT_PIN,
  input wire logic        DEBUG_PORT_OE
);
  logic       pol_up_q;
  logic       pol_lo_q;
  logic       en_q;
  logic [5:0] dead_q;
  logic [2:0] idle_q;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of written controls and idle time
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      {pol_up_q, pol_lo_q, en_q, dead_q, idle_q} <= '0;
    end
    else
    begin
      if (WR && ADDR == A_DEAD)
        dead_q <= WDATA[5:0];
      if (WR && ADDR == A_PWM_CTRL_LO)
      begin
        {pol_up_q, pol_lo_q} <= {WDATA[B_POL_UP], WDATA[B_POL_LO]};
        en_q <= WDATA[B_PWM_EN];
        idle_q <= 3'h0;
      end
      else if (!en_q && idle_q != 3'h7)
        idle_q <= idle_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_dbg_oe_follow: assert property (WR && ADDR == A_MT_CTRL_HI |=>
    DEBUG_PORT_OE == $past(WDATA[B_DBG_EN])) else $error("debug enable wrong");
  a_dbg_pin_gate: assert property (!DEBUG_PORT_OE |-> !DEBUG_PORT_PIN)
    else $error("debug pin driven while off");
  a_int_single: assert property (PWM_INT |=> !PWM_INT)
    else $error("interrupt longer than one cycle");
  a_wo_bits_zero: assert property (RD && ADDR[15:1] == A_MT_CTRL_LO[15:1]
    |=> !RDATA[2]) else $error("write-only bit reads one");
  a_dead_readback: assert property (RD && ADDR == A_DEAD |=>
    RDATA[5:0] == $past(dead_q)) else $error("dead time readback wrong");
  a_idle_levels: assert property (idle_q >= 3'h5 |-> PHASE_UPPER == {3{~pol_up_q}}
    && PHASE_LOWER == {3{~pol_lo_q}}) else $error("gates active while off");
  a_dir_idle_up: assert property (RD && ADDR == A_OUT_HI && idle_q >= 3'h5
    |=> !RDATA[B_DIR - 8]) else $error("direction not up while off");
  a_no_int_idle: assert property (idle_q >= 3'h5 |-> !PWM_INT)
    else $error("interrupt while off");
  c_int: cover property (PWM_INT);
  c_dbg: cover property (DEBUG_PORT_PIN);
  c_cap: cover property (RD && ADDR == A_MT_CAP_LO);
endmodule : mpwm_top_chk

// ==== bench/mpwm_top_tb.sv ====
// Self-checking bench for the motor PWM unit
`timescale 1ns/10ps
module mpwm_top_tb;
  import mpwm_pkg::*;
  logic        clk, resetn, wr, rd, pol_up, pol_lo, pwm_int, dbg, dbg_oe;
  logic [15:0] addr, v, w;
  logic [7:0]  wdata, rdata, b, d;
  logic [2:0]  up, lo, up_on, lo_on;
  logic [4:0]  evt_req, evt;
  logic [31:0] seed;
  int          fail_count, n_checks, c, e;
  logic [7:0]  rbit [3] = '{8'h02, 8'h08, 8'h10};
  int          evn [3] = '{0, 1, 4};
  ////////////////////////////////////////////////////////////////////////////
  // Unit, far side and checker
  mpwm_top dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .POS_DETECT(evt[0]), .OVERLOAD(evt[1]),
    .TIMER1_EVT(evt[2]), .TIMER2_EVT(evt[3]), .TIMER3_EVT(evt[4]), .PHASE_UPPER(up),
    .PHASE_LOWER(lo), .PWM_INT(pwm_int), .DEBUG_PORT_PIN(dbg), .DEBUG_PORT_OE(dbg_oe));
  mpwm_drv_model drv (.POL_UP(pol_up), .POL_LO(pol_lo), .PHASE_UPPER(up),
    .PHASE_LOWER(lo), .EVT_REQ(evt_req), .UP_ON(up_on), .LO_ON(lo_on), .EVT(evt));
  // Clock
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] g, input int l, input int h);
    n_checks++;
    if ((g >= 16'(l) && g <= 16'(h)) !== 1'b1)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h..%h", $time, g, 16'(l), 16'(h));
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask : rd_reg
  task automatic rd16(input logic [15:0] a, output logic [15:0] x);
    rd_reg(a, x[7:0]);
    rd_reg(a + 16'h1, x[15:8]);
  endtask : rd16
  task automatic pulse(input int i);
    @(posedge clk);
    evt_req[i] <= 1'b1;
    @(posedge clk);
    evt_req[i] <= 1'b0;
  endtask : pulse
  task automatic pwm_cfg(input logic [1:0] k, input logic [7:0] x);
    pol_up = x[B_POL_UP];
    pol_lo = x[B_POL_LO];
    wr_reg(A_PWM_CTRL_HI, {6'h00, k});
    wr_reg(A_PWM_CTRL_LO, x);
  endtask : pwm_cfg
  // Cycles from one interrupt pulse to the next
  task automatic wait_int(output int n);
    n = 0;
    @(posedge clk);
    while (pwm_int !== 1'b1 && n < 5000)
    begin
      n++;
      @(posedge clk);
    end
  endtask : wait_int
  task automatic gap(input int x);
    repeat (3) wait_int(c);
    chk(16'(c + 1), x, x);
  endtask : gap
  // Active cycles per upper gate and debug pin over ten periods
  task automatic duty(input int eu, input int ev, input int ew, input int ed);
    int cu, cv, cw, cd;
    {cu, cv, cw, cd} = '0;
    cyc(40);
    repeat (320)
    begin
      @(posedge clk);
      cu += int'(up_on[0] === 1'b1);
      cv += int'(up_on[1] === 1'b1);
      cw += int'(up_on[2] === 1'b1);
      cd += int'(dbg === 1'b1);
    end
    chk(16'(cu), eu, eu);
    chk(16'(cv), ev, ev);
    chk(16'(cw), ew, ew);
    chk(16'(cd), ed, ed);
  endtask : duty
  function automatic int mt_exp(input int i, input int t);
    return (i == 1) ? t >> 7 : (i % 2 == 1) ? 0 : t >> (3 + i / 2);
  endfunction : mt_exp
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(60000 * 8);
    fail_count++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {clk, resetn, wr, rd, addr, wdata, evt_req, pol_up, pol_lo} = '0;
    {fail_count, n_checks} = '0;
    seed = 32'ha6d4;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(A_MT_CTRL_HI, b);
    chk(b[B_OVF], 0, 0);
    for (int i = 0; i < 4; i++)
    begin
      d = rnd();
      wr_reg(A_DEAD, d);
      rd_reg(A_DEAD, b);
      chk(b[5:0], d[5:0], d[5:0]);
      wr_reg(A_OUT_HI, d);
      cyc(2);
      rd_reg(A_OUT_HI, b);
      chk(b[6:0], d[6:0], d[6:0]);
    end
    // Mode timer rate per clock code, reserved codes stand still
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(A_MT_CTRL_LO, {i[2:0], 5'h05});
      cyc(400);
      wr_reg(A_MT_CTRL_HI, 8'h04);
      rd16(A_MT_CAP_LO, v);
      e = mt_exp(i, 402);
      chk(v, (e > 0) ? e - 1 : 0, (e > 0) ? e + 1 : 0);
    end
    // Run 52 clocks at fc/8, then stop and see the count hold
    wr_reg(A_MT_CTRL_LO, 8'h01);
    cyc(50);
    wr_reg(A_MT_CTRL_LO, 8'h00);
    wr_reg(A_MT_CTRL_HI, 8'h04);
    rd16(A_MT_CAP_LO, v);
    chk(v, 6, 7);
    cyc(100);
    wr_reg(A_MT_CTRL_HI, 8'h04);
    rd16(A_MT_CAP_LO, w);
    chk(w, v, v);
    // Event capture for pos and overload, clear per source
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(A_MT_CTRL_HI, 8'h0a);
      wr_reg(A_MT_CTRL_LO, 8'h05 | rbit[i]);
      cyc(200);
      pulse(evn[i]);
      rd16(A_MT_CAP_LO, v);
      if (i < 2)
        chk(v, 24, 26);
      wr_reg(A_MT_CTRL_HI, 8'h04);
      rd16(A_MT_CAP_LO, v);
      chk(v, 0, 1);
    end
    // Interrupt spacing per mode, decimation and clock
    wr_reg(A_PRD_HI, 8'h00);
    wr_reg(A_PRD_LO, 8'h10);
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 4; k++)
      begin
        pwm_cfg(2'h0, {4'h0, k[1:0], m[0], 1'b1});
        gap((32 * (m + 1)) << k);
      end
    pwm_cfg(2'h2, 8'h01);
    gap(128);
    pwm_cfg(2'h3, 8'h01);
    gap(256);
    pwm_cfg(2'h0, 8'h81);
    gap(16);
    pwm_cfg(2'h0, 8'h83);
    gap(32);
    // Direction during triangle count
    pwm_cfg(2'h3, 8'h03);
    repeat (2) wait_int(c);
    rd_reg(A_OUT_HI, b);
    chk(b[7], 0, 0);
    cyc(300);
    rd_reg(A_OUT_HI, b);
    chk(b[7], 1, 1);
    // Static levels and synchronised updates
    wr_reg(A_DEAD, 8'h00);
    wr_reg(A_OUT_LO, 8'h06);
    wr_reg(A_OUT_HI, 8'h00);
    pwm_cfg(2'h0, 8'h21);
    cyc(8);
    chk(up_on, 1, 1);
    chk(lo_on, 2, 2);
    for (int s = 1; s < 4; s++)
    begin
      d = {s[1:0], (s % 2 == 1) ? 6'h09 : 6'h06};
      wr_reg(A_OUT_LO, d);
      cyc(10);
      chk(up_on, (s % 2 == 1) ? 1 : 2, (s % 2 == 1) ? 1 : 2);
      pulse((s == 1) ? 0 : s);
      cyc(6);
      chk(up_on, {d[5], d[3], d[1]}, {d[5], d[3], d[1]});
      chk(lo_on, {d[4], d[2], d[0]}, {d[4], d[2], d[0]});
    end
    // Waveform duty per phase in both duty modes
    wr_reg(A_OUT_LO, 8'h2a);
    wr_reg(A_OUT_HI, 8'h07);
    wr_reg(A_DUTY_U_LO, 8'h04);
    wr_reg(A_DUTY_V_LO, 8'h0c);
    wr_reg(A_DUTY_W_LO, 8'h08);
    wr_reg(A_MT_CTRL_HI, 8'h80);
    pwm_cfg(2'h0, 8'h21);
    duty(80, 80, 80, 80);
    pwm_cfg(2'h0, 8'h61);
    duty(80, 240, 160, 80);
    // Eight dead clocks cut each upper pulse short
    wr_reg(A_DEAD, 8'h01);
    duty(0, 160, 80, 80);
    pwm_cfg(2'h0, 8'h20);
    cyc(8);
    chk(up_on, 0, 0);
    stop_test();
  end
endmodule : mpwm_top_tb
bind mpwm_top mpwm_top_chk chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .PHASE_UPPER(PHASE_UPPER), .PHASE_LOWER(PHASE_LOWER),
  .PWM_INT(PWM_INT), .DEBUG_PORT_PIN(DEBUG_PORT_PIN), .DEBUG_PORT_OE(DEBUG_PORT_OE));

// ==== rtl/mpwm_pkg.sv ====
// Constants for the motor PWM waveform unit and its mode timer
package mpwm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte addresses
  localparam logic [15:0] A_MT_CTRL_LO  = 16'h1fa4;
  localparam logic [15:0] A_MT_CTRL_HI  = 16'h1fa5;
  localparam logic [15:0] A_MT_CAP_LO   = 16'h1fa6;
  localparam logic [15:0] A_MT_CAP_HI   = 16'h1fa7;
  localparam logic [15:0] A_MODE_COMPARE_ONE_LO     = 16'h1fa8;
  localparam logic [15:0] A_MODE_COMPARE_ONE_HI     = 16'h1fa9;
  localparam logic [15:0] A_MODE_COMPARE_TWO_LO     = 16'h1faa;
  localparam logic [15:0] A_MODE_COMPARE_TWO_HI     = 16'h1fab;
  localparam logic [15:0] A_MODE_COMPARE_THREE_LO     = 16'h1fac;
  localparam logic [15:0] A_MODE_COMPARE_THREE_HI     = 16'h1fad;
  localparam logic [15:0] A_PWM_CTRL_LO = 16'h1fae;
  localparam logic [15:0] A_PWM_CTRL_HI = 16'h1faf;
  localparam logic [15:0] A_OUT_LO      = 16'h1fb2;
  localparam logic [15:0] A_OUT_HI      = 16'h1fb3;
  localparam logic [15:0] A_PRD_LO      = 16'h1fb6;
  localparam logic [15:0] A_PRD_HI      = 16'h1fb7;
  localparam logic [15:0] A_DUTY_U_LO   = 16'h1fb8;
  localparam logic [15:0] A_DUTY_U_HI   = 16'h1fb9;
  localparam logic [15:0] A_DUTY_V_LO   = 16'h1fba;
  localparam logic [15:0] A_DUTY_V_HI   = 16'h1fbb;
  localparam logic [15:0] A_DUTY_W_LO   = 16'h1fbc;
  localparam logic [15:0] A_DUTY_W_HI   = 16'h1fbd;
  localparam logic [15:0] A_DEAD        = 16'h1fbe;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, mode timer control
  localparam int B_MT_EN      = 0;
  localparam int B_MT_RST_POS = 1;
  localparam int B_MT_RST_SW  = 2;
  localparam int B_MT_RST_OVL = 3;
  localparam int B_MT_RST_T3  = 4;
  localparam int B_MT_CLK_LSB = 5;
  localparam int B_CAP_POS    = 1;
  localparam int B_CAP_SW     = 2;
  localparam int B_CAP_OVL    = 3;
  localparam int B_OVF        = 5;
  localparam int B_DBG_EN     = 7;
  // Field positions, PWM control
  localparam int B_PWM_EN     = 0;
  localparam int B_PWM_MODE   = 1;
  localparam int B_DEC_LSB    = 2;
  localparam int B_POL_LO     = 4;
  localparam int B_POL_UP     = 5;
  localparam int B_DUTY_IND   = 6;
  localparam int B_HALF       = 7;
  // Field positions, phase output control
  localparam int B_SYNC_LSB   = 6;
  localparam int B_SEL_LSB    = 8;
  localparam int B_PSYNC      = 11;
  localparam int B_PAT_LSB    = 12;
  localparam int B_DIR        = 15;

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection codes and prescaler shifts
  localparam logic [2:0] MT_CLK_8   = 3'h0;
  localparam logic [2:0] MT_CLK_16  = 3'h2;
  localparam logic [2:0] MT_CLK_32  = 3'h4;
  localparam logic [2:0] MT_CLK_64  = 3'h6;
  localparam logic [2:0] MT_CLK_128 = 3'h1;
  localparam logic [1:0] PW_CLK_2   = 2'h0;
  localparam logic [1:0] PW_CLK_8   = 2'h2;
  localparam logic [1:0] PW_CLK_16  = 2'h3;
  // Output synchronising sources
  localparam logic [1:0] SY_NOW     = 2'h0;
  localparam logic [1:0] SY_POS     = 2'h1;
  localparam logic [1:0] SY_T1      = 2'h2;
  localparam logic [1:0] SY_T2      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Timing and reset values
  localparam int          DEAD_UNIT_CYC = 8;
  localparam logic [11:0] PRD_MIN       = 12'h010;
  localparam logic [11:0] PRD_RST       = 12'hfff;

endpackage : mpwm_pkg

// ==== rtl/mpwm_prescaler.sv ====
// Free-running divider giving a one-cycle tick every 2**shift clocks
`timescale 1ns/10ps
module mpwm_prescaler #(
  parameter int W = 7
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RESETN,
  // Division select
  input  wire logic [2:0]   SHIFT,
  input  wire logic         VALID,
  // Tick out
  output      logic         TICK
);
  import mpwm_pkg::*;

  // Refuse widths the divider cannot serve
  if (W < 1 || W > 7)
  begin : g_bad_w
    $error("mpwm_prescaler: W must be 1 to 7");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
  } mpwm_ps_t;

  mpwm_ps_t q;
  mpwm_ps_t d;
  logic [W-1:0] mask;

  // Mask of the low bits that must all be one
  assign mask = W'((8'h01 << SHIFT) - 8'h01);
  assign TICK = VALID && ((q.cnt & mask) == mask);

  // Next count
  always_comb
  begin
    d     = q;
    d.cnt = q.cnt + 1'b1;
  end

  // State register
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      q <= '0;
    else
      q <= d;
  end

endmodule : mpwm_prescaler

// ==== rtl/mpwm_top.sv ====
// Motor PWM waveform unit with mode timer and register port
`timescale 1ns/10ps
module mpwm_top #(
  parameter int PW = 12
) (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RESETN,
  // Register port
  input  wire logic [15:0]  ADDR,
  input  wire logic [7:0]   WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output      logic [7:0]   RDATA,
  // Events from neighbouring blocks
  input  wire logic         POS_DETECT,
  input  wire logic         OVERLOAD,
  input  wire logic         TIMER1_EVT,
  input  wire logic         TIMER2_EVT,
  input  wire logic         TIMER3_EVT,
  // Gate driver outputs, index 0 U, 1 V, 2 W
  output      logic [2:0]   PHASE_UPPER,
  output      logic [2:0]   PHASE_LOWER,
  // PWM interrupt request
  output      logic         PWM_INT,
  // Debug port pin
  output      logic         DEBUG_PORT_PIN,
  output      logic         DEBUG_PORT_OE
);
  import mpwm_pkg::*;

  if (PW < 8 || PW > 16)
  begin : g_bad_pw
    $error("mpwm_top: PW must be 8 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0]          mt_lo;
    logic [7:0]          mt_hi;
    logic [15:0]         mcnt;
    logic [15:0]         mode_timer_capture;
    logic                ovf;
    logic [15:0]         mode_compare_one;
    logic [15:0]         mode_compare_two;
    logic [15:0]         mode_compare_three;
    logic [7:0]          pw_lo;
    logic [7:0]          pw_hi;
    logic [15:0]         out_sh;
    logic [15:0]         out_act;
    logic                pend;
    logic [5:0]          dead;
    logic [PW-1:0]       prd;
    logic [2:0][PW-1:0]  duty;
    logic [PW-1:0]       pcnt;
    logic                dir;
    logic [2:0]          dec;
    logic [2:0]          raw;
    logic [2:0][8:0]     dcnt;
    logic [2:0]          up_n;
    logic [2:0]          lo_n;
    logic                pwm_interrupt_decimation;
    logic                dbg;
    logic [7:0]          rdata;
  } mpwm_st_t;

  mpwm_st_t q;
  mpwm_st_t d;

  logic [2:0]    mt_shift;
  logic          mt_valid;
  logic [2:0]    pw_shift;
  logic          pw_valid;
  logic          mt_tick;
  logic          pw_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Clock selection decode
  always_comb
  begin
    mt_valid = 1'b1;
    case (q.mt_lo[B_MT_CLK_LSB +: 3])
      MT_CLK_8:   mt_shift = 3'h3;
      MT_CLK_16:  mt_shift = 3'h4;
      MT_CLK_32:  mt_shift = 3'h5;
      MT_CLK_64:  mt_shift = 3'h6;
      MT_CLK_128: mt_shift = 3'h7;
      default:
      begin
        mt_shift = 3'h3;
        mt_valid = 1'b0;  // Reserved codes hold the timer
      end
    endcase
    pw_valid = 1'b1;
    case (q.pw_hi[1:0])
      PW_CLK_2:  pw_shift = 3'h1;
      PW_CLK_8:  pw_shift = 3'h3;
      PW_CLK_16: pw_shift = 3'h4;
      default:
      begin
        pw_shift = 3'h1;
        pw_valid = 1'b0;
      end
    endcase
  end

  // Mode timer prescaler
  mpwm_prescaler #(.W(7)) u_mt_ps (
    .CLK    (CLK),
    .RESETN (RESETN),
    .SHIFT  (mt_shift),
    .VALID  (mt_valid),
    .TICK   (mt_tick)
  );

  // PWM counter prescaler
  mpwm_prescaler #(.W(7)) u_pw_ps (
    .CLK    (CLK),
    .RESETN (RESETN),
    .SHIFT  (pw_shift),
    .VALID  (pw_valid),
    .TICK   (pw_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic          sw_rst, sw_cap, clr, cap, run;
    logic          per_evt, half_evt, sync_evt, wu, wl, au, al;
    logic [2:0]    lim;
    logic [2:0]    raw;
    logic [PW-1:0] dsel;
    {sw_rst, sw_cap, clr, cap, run} = '0;
    {per_evt, half_evt, sync_evt, wu, wl, au, al} = '0;
    lim      = 3'h0;
    raw      = 3'h0;
    dsel     = '0;
    d        = q;
    d.pwm_interrupt_decimation   = 1'b0;
    d.rdata  = 8'h00;

    // Register writes; command bits are not stored
    if (WR)
    begin
      case (ADDR)
        A_MT_CTRL_LO:
        begin
          d.mt_lo = WDATA & ~(8'h01 << B_MT_RST_SW);
          sw_rst  = WDATA[B_MT_RST_SW];
        end
        A_MT_CTRL_HI:
        begin
          d.mt_hi = WDATA & 8'h8a;
          sw_cap  = WDATA[B_CAP_SW];
        end
        A_MODE_COMPARE_ONE_LO:     d.mode_compare_one[7:0]   = WDATA;
        A_MODE_COMPARE_ONE_HI:     d.mode_compare_one[15:8]  = WDATA;
        A_MODE_COMPARE_TWO_LO:     d.mode_compare_two[7:0]   = WDATA;
        A_MODE_COMPARE_TWO_HI:     d.mode_compare_two[15:8]  = WDATA;
        A_MODE_COMPARE_THREE_LO:     d.mode_compare_three[7:0]   = WDATA;
        A_MODE_COMPARE_THREE_HI:     d.mode_compare_three[15:8]  = WDATA;
        A_PWM_CTRL_LO: d.pw_lo       = WDATA;
        A_PWM_CTRL_HI: d.pw_hi       = WDATA & 8'h03;
        A_OUT_LO:      d.out_sh[7:0] = WDATA;
        A_OUT_HI:      d.out_sh[15:8] = WDATA & 8'h7f;
        A_PRD_LO:      d.prd = PW'({q.prd, 8'h00} >> 8) & ~PW'(8'hff) | PW'(WDATA);
        A_PRD_HI:      d.prd = PW'({WDATA, q.prd[7:0]});
        A_DUTY_U_LO:   d.duty[0] = (q.duty[0] & ~PW'(8'hff)) | PW'(WDATA);
        A_DUTY_U_HI:   d.duty[0] = PW'({WDATA, q.duty[0][7:0]});
        A_DUTY_V_LO:   d.duty[1] = (q.duty[1] & ~PW'(8'hff)) | PW'(WDATA);
        A_DUTY_V_HI:   d.duty[1] = PW'({WDATA, q.duty[1][7:0]});
        A_DUTY_W_LO:   d.duty[2] = (q.duty[2] & ~PW'(8'hff)) | PW'(WDATA);
        A_DUTY_W_HI:   d.duty[2] = PW'({WDATA, q.duty[2][7:0]});
        A_DEAD:        d.dead = WDATA[5:0];
        default:       d.dead = q.dead;
      endcase
    end

    // Mode timer clear and capture sources
    clr = sw_rst
        | (TIMER3_EVT & q.mt_lo[B_MT_RST_T3])
        | (OVERLOAD   & q.mt_lo[B_MT_RST_OVL])
        | (POS_DETECT & q.mt_lo[B_MT_RST_POS]);
    cap = sw_cap
        | (OVERLOAD   & q.mt_hi[B_CAP_OVL])
        | (POS_DETECT & q.mt_hi[B_CAP_POS]);

    // Capture copies the count as it stands
    if (cap)
      d.mode_timer_capture = q.mcnt;

    // Overflow flag clears on read of the high control byte
    if (RD && ADDR == A_MT_CTRL_HI)
      d.ovf = 1'b0;

    // Mode timer count; overflow set wins over read clear
    if (clr)
      d.mcnt = 16'h0000;
    else if (q.mt_lo[B_MT_EN] && mt_tick)
    begin
      d.mcnt = q.mcnt + 16'h0001;
      if (q.mcnt == 16'hffff)
        d.ovf = 1'b1;
    end

    // PWM counter, sawtooth or triangle
    run = q.pw_lo[B_PWM_EN];
    if (!run)
    begin
      d.pcnt = '0;
      d.dir  = 1'b0;
      d.dec  = 3'h0;
    end
    else if (pw_tick)
    begin
      if (!q.pw_lo[B_PWM_MODE])
      begin
        // Edge-aligned: count 0 .. period-1 then wrap
        if (q.pcnt >= q.prd - 1'b1)
        begin
          d.pcnt  = '0;
          per_evt = 1'b1;
        end
        else
        begin
          d.pcnt   = q.pcnt + 1'b1;
          half_evt = (q.pcnt == (q.prd >> 1) - 1'b1);
        end
      end
      else if (!q.dir)
      begin
        // Centre-aligned: count up to period then turn
        if (q.pcnt >= q.prd)
        begin
          d.dir    = 1'b1;
          d.pcnt   = q.pcnt - 1'b1;
          half_evt = 1'b1;
        end
        else
          d.pcnt = q.pcnt + 1'b1;
      end
      else if (q.pcnt == '0)
      begin
        d.dir   = 1'b0;
        d.pcnt  = q.pcnt + 1'b1;
        per_evt = 1'b1;
      end
      else
        d.pcnt = q.pcnt - 1'b1;
    end

    // Interrupt decimation and half-period request
    lim = 3'((4'h1 << q.pw_lo[B_DEC_LSB +: 2]) - 4'h1);
    if (q.pw_lo[B_HALF] && q.pw_lo[B_DEC_LSB +: 2] == 2'h0)
      d.pwm_interrupt_decimation = per_evt | half_evt;
    else if (per_evt)
    begin
      if (q.dec >= lim)
      begin
        d.dec  = 3'h0;
        d.pwm_interrupt_decimation = 1'b1;
      end
      else
        d.dec = q.dec + 3'h1;
    end

    // Output control update moment
    case (q.out_sh[B_SYNC_LSB +: 2])
      SY_NOW:  sync_evt = 1'b1;
      SY_POS:  sync_evt = POS_DETECT;
      SY_T1:   sync_evt = TIMER1_EVT;
      SY_T2:   sync_evt = TIMER2_EVT;
      default: sync_evt = 1'b0;
    endcase
    if (sync_evt)
      d.pend = 1'b1;
    if (q.pend && (!q.out_sh[B_PSYNC] || per_evt))
    begin
      d.out_act = q.out_sh;
      d.pend    = sync_evt;
    end
    if (WR && (ADDR == A_OUT_LO || ADDR == A_OUT_HI))
      d.pend = 1'b0;  // New settings wait for a fresh sync event

    // Per-phase duty, dead time and output drive
    for (int i = 0; i < 3; i++)
    begin
      dsel   = q.pw_lo[B_DUTY_IND] ? q.duty[i] : q.duty[0];
      raw[i] = run && (q.pcnt < dsel);
      if (raw[i] != q.raw[i])
        d.dcnt[i] = 9'(q.dead * DEAD_UNIT_CYC);
      else if (q.dcnt[i] != 9'h000)
        d.dcnt[i] = q.dcnt[i] - 9'h001;
      d.raw[i] = raw[i];
      wu = q.raw[i] && q.dcnt[i] == 9'h000;
      wl = !q.raw[i] && q.dcnt[i] == 9'h000;
      if (q.out_act[B_SEL_LSB + i])
      begin
        au = run && wu && q.out_act[2*i+1];
        al = run && wl && q.out_act[2*i];
      end
      else
      begin
        au = run && q.out_act[2*i+1];
        al = run && q.out_act[2*i];
      end
      // Stored inverted so that reset leaves pins at the idle level
      d.up_n[i] = ~(q.pw_lo[B_POL_UP] ? au : ~au);
      d.lo_n[i] = ~(q.pw_lo[B_POL_LO] ? al : ~al);
    end

    // Debug signal: raw U-phase waveform
    d.dbg = q.raw[0];

    // Read data, valid the cycle after the strobe
    if (RD)
    begin
      case (ADDR)
        A_MT_CTRL_LO:  d.rdata = q.mt_lo;
        A_MT_CTRL_HI:  d.rdata = q.mt_hi | (8'(q.ovf) << B_OVF);
        A_MT_CAP_LO:   d.rdata = q.mode_timer_capture[7:0];
        A_MT_CAP_HI:   d.rdata = q.mode_timer_capture[15:8];
        A_MODE_COMPARE_ONE_LO:     d.rdata = q.mode_compare_one[7:0];
        A_MODE_COMPARE_ONE_HI:     d.rdata = q.mode_compare_one[15:8];
        A_MODE_COMPARE_TWO_LO:     d.rdata = q.mode_compare_two[7:0];
        A_MODE_COMPARE_TWO_HI:     d.rdata = q.mode_compare_two[15:8];
        A_MODE_COMPARE_THREE_LO:     d.rdata = q.mode_compare_three[7:0];
        A_MODE_COMPARE_THREE_HI:     d.rdata = q.mode_compare_three[15:8];
        A_PWM_CTRL_LO: d.rdata = q.pw_lo;
        A_PWM_CTRL_HI: d.rdata = q.pw_hi;
        A_OUT_LO:      d.rdata = q.out_sh[7:0];
        A_OUT_HI:      d.rdata = {q.dir, q.out_sh[14:8]};
        A_PRD_LO:      d.rdata = q.prd[7:0];
        A_PRD_HI:      d.rdata = 8'(q.prd >> 8);
        A_DUTY_U_LO:   d.rdata = q.duty[0][7:0];
        A_DUTY_U_HI:   d.rdata = 8'(q.duty[0] >> 8);
        A_DUTY_V_LO:   d.rdata = q.duty[1][7:0];
        A_DUTY_V_HI:   d.rdata = 8'(q.duty[1] >> 8);
        A_DUTY_W_LO:   d.rdata = q.duty[2][7:0];
        A_DUTY_W_HI:   d.rdata = 8'(q.duty[2] >> 8);
        A_DEAD:        d.rdata = {2'h0, q.dead};
        default:       d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      q     <= '0;
      q.prd <= PW'(PRD_RST);
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign RDATA          = q.rdata;
  assign PHASE_UPPER    = ~q.up_n;
  assign PHASE_LOWER    = ~q.lo_n;
  assign PWM_INT        = q.pwm_interrupt_decimation;
  assign DEBUG_PORT_PIN = q.dbg & q.mt_hi[B_DBG_EN];
  assign DEBUG_PORT_OE  = q.mt_hi[B_DBG_EN];

endmodule : mpwm_top
